// ### design/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// register offsets on the plain register port
`define SSP_OFS_DATA     24'hfffe60
`define SSP_OFS_CTRL     24'hfffe62
`define SSP_OFS_STAT     24'hfffe64

// control register field positions
`define SSP_CTL_EN       0
`define SSP_CTL_MST      1
`define SSP_CTL_WIDE     2
`define SSP_CTL_ECHO     3
`define SSP_CTL_EIO      4
`define SSP_CTL_EIR      5
`define SSP_CTL_EIW      6
`define SSP_CTL_SCM      7
`define SSP_CTL_IDLE     8
`define SSP_CTL_DIV_LSB  9
`define SSP_CTL_DIV_MSB  15

// status register field positions
`define SSP_ST_BSY       0
`define SSP_ST_RBF       1
`define SSP_ST_OVR       2

// reset values
`define SSP_CTRL_RST     16'h0000
`define SSP_DATA_RST     16'h0000

// transfer lengths in bits
`define SSP_BITS_WIDE    5'd16
`define SSP_BITS_BYTE    5'd8

`endif

// ### design/ssp_pkg.sv
package ssp_pkg;

	// shifter sequencing, gray coded along idle -> shift -> hold
	typedef enum logic [1:0]
	{
		SSP_IDLE  = 2'b00,
		SSP_SHIFT = 2'b01,
		SSP_HOLD  = 2'b11
	} ssp_state_type;

endpackage

// ### design/ssp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser for asynchronous pin levels
module ssp_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// raw level in, synchronised level out
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;	// first stage, read only by the second

	// both stages in one process; only q leaves this module
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= INIT;
			q      <= INIT;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ### design/ssp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.svh"

module ssp_top (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// register port
	input  wire logic [23:0] ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output var  logic [15:0] RDATA,
	// shift clock pin
	input  wire logic        SHIFT_CLOCK_PIN_I,
	output var  logic        SHIFT_CLOCK_PIN_O,
	output var  logic        SHIFT_CLOCK_PIN_OE,
	// master-out / slave-in pin
	input  wire logic        MASTER_OUT_SLAVE_IN_PIN_I,
	output wire logic        MASTER_OUT_SLAVE_IN_PIN_O,
	output var  logic        MASTER_OUT_SLAVE_IN_PIN_OE,
	// master-in / slave-out pin
	input  wire logic        MASTER_IN_SLAVE_OUT_PIN_I,
	output wire logic        MASTER_IN_SLAVE_OUT_PIN_O,
	output var  logic        MASTER_IN_SLAVE_OUT_PIN_OE,
	// slave select, active low
	input  wire logic        SLAVE_SELECT_N,
	// interrupt, active high level
	output var  logic        IRQ
);

	ssp_pkg::ssp_state_type state_r;	// shifter sequencing

	logic [15:0] ctrl_r;		// port control register
	logic [15:0] shift_r;		// shifter
	logic [15:0] rdbuf_r;		// read buffer
	logic        rbf_r;			// read buffer full
	logic        ovr_r;			// receive overrun
	logic        valid_r;		// shifter holds software data
	logic [4:0]  bitcnt_r;		// sampled bits so far
	logic [5:0]  hcnt_r;		// master half periods so far
	logic [6:0]  div_cnt_r;		// divider count
	logic        sck_r;			// master shift clock
	logic        first_r;		// no leading edge seen yet
	logic        in_last_r;		// last sampled bit, for echo
	logic        out_bit_r;		// serial output bit
	logic        sck_d_r;		// delayed synchronised clock
	logic        ss_n_d_r;		// delayed synchronised select
	logic        sck_q;			// synchronised slave clock
	logic        mosi_q;		// synchronised slave data in
	logic        ss_n_q;		// synchronised select

	// control fields
	logic        en, mst, wide, echo, overrun_irq_enable_bit, read_full_irq_enable, transfer_done_irq_enable, clock_edge_mode_bit, idle;
	logic [6:0]  div;
	logic [4:0]  nbits;			// bits per transfer
	logic [15:0] stat_v;		// status read value
	// decode and events
	logic        wr_data, wr_ctrl, wr_stat, rd_data, rd_ctrl, rd_stat;
	logic        busy, s_edge, s_lead, m_tick, m_lead, edge_evt, edge_lead;
	logic        samp_on_lead, samp_evt, out_evt, in_bit, m_done, s_done;
	logic        done_evt, start_m, load_s, load_any, buf_free, buf_load;
	logic        hold_rel, s_restart, ss_assert, echo_act;
	logic [15:0] sh_cap;		// shifter value including this cycle's sample

	// shift one bit in; byte mode moves only the low byte
	function automatic logic [15:0] shift_in(input logic [15:0] s, input logic w,
		input logic b);
		shift_in = w ? {s[14:0], b} : {s[15:8], s[6:0], b};
	endfunction

	// bit currently at the output end of the shifter
	function automatic logic top_bit(input logic [15:0] s, input logic w);
		top_bit = w ? s[15] : s[7];
	endfunction

	// value the read buffer takes from a shifter value
	function automatic logic [15:0] merge(input logic [15:0] b, input logic [15:0] s,
		input logic w);
		merge = w ? s : {b[15:8], s[7:0]};
	endfunction

	assign en    = ctrl_r[`SSP_CTL_EN];
	assign mst   = ctrl_r[`SSP_CTL_MST];
	assign wide  = ctrl_r[`SSP_CTL_WIDE];
	assign echo  = ctrl_r[`SSP_CTL_ECHO];
	assign overrun_irq_enable_bit   = ctrl_r[`SSP_CTL_EIO];
	assign read_full_irq_enable   = ctrl_r[`SSP_CTL_EIR];
	assign transfer_done_irq_enable   = ctrl_r[`SSP_CTL_EIW];
	assign clock_edge_mode_bit   = ctrl_r[`SSP_CTL_SCM];
	assign idle  = ctrl_r[`SSP_CTL_IDLE];
	assign div   = ctrl_r[`SSP_CTL_DIV_MSB:`SSP_CTL_DIV_LSB];
	assign nbits = wide ? `SSP_BITS_WIDE : `SSP_BITS_BYTE;
	assign busy  = (state_r != ssp_pkg::SSP_IDLE);

	// address decode, strobes qualified per register
	assign wr_data = WR && (ADDR == `SSP_OFS_DATA);
	assign wr_ctrl = WR && (ADDR == `SSP_OFS_CTRL);
	assign wr_stat = WR && (ADDR == `SSP_OFS_STAT);
	assign rd_data = RD && (ADDR == `SSP_OFS_DATA);
	assign rd_ctrl = RD && (ADDR == `SSP_OFS_CTRL);
	assign rd_stat = RD && (ADDR == `SSP_OFS_STAT);

	// slave-side pins cross into the system clock before edge detection
	ssp_sync #(
		.W    (3),
		.INIT (3'h1)
	) u_sync (
		.clk (CLK),
		.rst (RST),
		.d   ({SHIFT_CLOCK_PIN_I, MASTER_OUT_SLAVE_IN_PIN_I, SLAVE_SELECT_N}),
		.q   ({sck_q, mosi_q, ss_n_q})
	);

	// delayed copies for edge detection, taken after the synchroniser
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			sck_d_r  <= 1'b0;
			ss_n_d_r <= 1'b1;
		end
		else
		begin
			sck_d_r  <= sck_q;
			ss_n_d_r <= ss_n_q;
		end
	end

	// slave edges count only while selected; slave rate is limited by the sync delay
	assign s_edge    = en && !mst && !ss_n_q && (state_r != ssp_pkg::SSP_HOLD)
		&& (sck_q != sck_d_r);
	assign s_lead    = (sck_d_r == idle);
	assign s_restart = !mst && ss_n_q && !ss_n_d_r;
	assign ss_assert = !mst && !ss_n_q && ss_n_d_r;
	// master half-period tick every div+1 system clocks
	assign m_tick    = en && mst && (state_r == ssp_pkg::SSP_SHIFT) && (div_cnt_r == div);
	assign m_lead    = (sck_r == idle);
	assign edge_evt  = mst ? m_tick : s_edge;
	assign edge_lead = mst ? m_lead : s_lead;
	// normal mode with low idle samples on the leading (rising) edge
	assign samp_on_lead = !(clock_edge_mode_bit ^ idle);
	assign samp_evt  = edge_evt && (edge_lead == samp_on_lead);
	// first leading output edge is skipped: msb was already presented
	assign out_evt   = edge_evt && (edge_lead != samp_on_lead) && !(edge_lead && first_r);
	assign in_bit    = mst ? MASTER_IN_SLAVE_OUT_PIN_I : mosi_q;
	assign sh_cap    = samp_evt ? shift_in(shift_r, wide, in_bit) : shift_r;
	assign m_done    = m_tick && (hcnt_r == ({nbits, 1'b0} - 6'd1));
	assign s_done    = !mst && samp_evt && (bitcnt_r == (nbits - 5'd1));
	assign done_evt  = m_done || s_done;
	// writes during a running transfer are dropped, software must wait for idle
	assign start_m   = wr_data && en && mst && (state_r != ssp_pkg::SSP_SHIFT);
	assign load_s    = wr_data && en && !mst && (state_r != ssp_pkg::SSP_SHIFT);
	assign load_any  = start_m || load_s;
	assign buf_free  = !rbf_r || rd_data;
	assign buf_load  = done_evt && buf_free;
	assign hold_rel  = en && rd_data && (state_r == ssp_pkg::SSP_HOLD);
	assign echo_act  = echo && !valid_r && !mst;

	// sequencing: idle, shifting, or finished but waiting for the buffer
	always_ff @(posedge CLK)
	begin
		if (RST || !en)
			state_r <= ssp_pkg::SSP_IDLE;
		else if (load_any)
			state_r <= ssp_pkg::SSP_SHIFT;
		else if (done_evt)
			state_r <= buf_free ? ssp_pkg::SSP_IDLE : ssp_pkg::SSP_HOLD;
		else if (hold_rel)
			state_r <= ssp_pkg::SSP_IDLE;
		else if (s_edge && (state_r == ssp_pkg::SSP_IDLE))
			state_r <= ssp_pkg::SSP_SHIFT;	// slave busy on first edge
	end

	// control register, written whole
	always_ff @(posedge CLK)
	begin
		if (RST)
			ctrl_r <= `SSP_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= WDATA;
	end

	// shifter: software load or one bit per sample edge
	always_ff @(posedge CLK)
	begin
		if (RST)
			shift_r <= `SSP_DATA_RST;
		else if (load_any)
			shift_r <= WDATA;
		else if (samp_evt)
			shift_r <= sh_cap;
	end

	// read buffer; a write never touches it
	always_ff @(posedge CLK)
	begin
		if (RST)
			rdbuf_r <= `SSP_DATA_RST;
		else if (buf_load)
			rdbuf_r <= merge(rdbuf_r, sh_cap, wide);
		else if (hold_rel)
			rdbuf_r <= merge(rdbuf_r, shift_r, wide);
	end

	// buffer full: load wins over the clearing read in the same cycle
	always_ff @(posedge CLK)
	begin
		if (RST || !en)
			rbf_r <= 1'b0;
		else if (buf_load || hold_rel)
			rbf_r <= 1'b1;
		else if (rd_data)
			rbf_r <= 1'b0;
	end

	// overrun: master start while finished data waits; cleared by writing one
	always_ff @(posedge CLK)
	begin
		if (RST || !en)
			ovr_r <= 1'b0;
		else if (start_m && (state_r == ssp_pkg::SSP_HOLD))
			ovr_r <= 1'b1;
		else if (wr_stat && WDATA[`SSP_ST_OVR])
			ovr_r <= 1'b0;
	end

	// software data valid from the write until the transfer ends
	always_ff @(posedge CLK)
	begin
		if (RST || !en)
			valid_r <= 1'b0;
		else if (load_any)
			valid_r <= 1'b1;
		else if (done_evt)
			valid_r <= 1'b0;
	end

	// bit counter, restarted by select deassertion
	always_ff @(posedge CLK)
	begin
		if (RST || !en || load_any || done_evt || s_restart)
			bitcnt_r <= 5'd0;
		else if (samp_evt)
			bitcnt_r <= bitcnt_r + 5'd1;
	end

	// leading-edge tracker for the skipped first output edge
	always_ff @(posedge CLK)
	begin
		if (RST || load_any || done_evt || s_restart || ss_assert)
			first_r <= 1'b1;
		else if (edge_evt && edge_lead)
			first_r <= 1'b0;
	end

	// last received bit, kept for echo
	always_ff @(posedge CLK)
	begin
		if (RST)
			in_last_r <= 1'b0;
		else if (samp_evt)
			in_last_r <= in_bit;
	end

	// output bit: msb presented early, then changed on the output edge
	always_ff @(posedge CLK)
	begin
		if (RST)
			out_bit_r <= 1'b0;
		else if (load_any)
			out_bit_r <= top_bit(WDATA, wide);
		else if (ss_assert)
			out_bit_r <= echo_act ? mosi_q : top_bit(shift_r, wide);
		else if (out_evt)
			out_bit_r <= echo_act ? in_last_r : top_bit(shift_r, wide);
	end

	// master divider runs only while shifting
	always_ff @(posedge CLK)
	begin
		if (RST || (state_r != ssp_pkg::SSP_SHIFT) || m_tick || load_any)
			div_cnt_r <= 7'd0;
		else
			div_cnt_r <= div_cnt_r + 7'd1;
	end

	// half-period count for the master burst
	always_ff @(posedge CLK)
	begin
		if (RST || load_any)
			hcnt_r <= 6'd0;
		else if (m_tick)
			hcnt_r <= hcnt_r + 6'd1;
	end

	// master clock toggles per tick, sits at idle level when not shifting
	always_ff @(posedge CLK)
	begin
		if (RST)
			sck_r <= 1'b0;
		else if (m_tick)
			sck_r <= !sck_r;
		else if (!mst || (state_r != ssp_pkg::SSP_SHIFT))
			sck_r <= idle;
	end

	// pin directions: master drives clock and data out; slave drives only when selected
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			SHIFT_CLOCK_PIN_OE         <= 1'b0;
			MASTER_OUT_SLAVE_IN_PIN_OE <= 1'b0;
			MASTER_IN_SLAVE_OUT_PIN_OE <= 1'b0;
		end
		else
		begin
			SHIFT_CLOCK_PIN_OE         <= mst;
			MASTER_OUT_SLAVE_IN_PIN_OE <= mst;
			MASTER_IN_SLAVE_OUT_PIN_OE <= en && !mst && !ss_n_q;
		end
	end

	assign SHIFT_CLOCK_PIN_O         = sck_r;
	assign MASTER_OUT_SLAVE_IN_PIN_O = out_bit_r;
	assign MASTER_IN_SLAVE_OUT_PIN_O = out_bit_r;

	// interrupt level from the three enabled sources
	always_ff @(posedge CLK)
	begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= (rbf_r && read_full_irq_enable) || (!busy && transfer_done_irq_enable) || (ovr_r && overrun_irq_enable_bit);
	end

	// status word, reserved bits zero
	always_comb
	begin
		stat_v = 16'h0000;
		stat_v[`SSP_ST_BSY] = busy;
		stat_v[`SSP_ST_RBF] = rbf_r;
		stat_v[`SSP_ST_OVR] = ovr_r;
	end

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge CLK)
	begin
		if (RST)
			RDATA <= 16'h0000;
		else if (rd_data)
			RDATA <= rdbuf_r;
		else if (rd_ctrl)
			RDATA <= ctrl_r;
		else if (rd_stat)
			RDATA <= stat_v;
		else
			RDATA <= 16'h0000;
	end

	// helper: master clock toggles since the burst started
	logic [5:0] tog_cnt_r;
	always_ff @(posedge CLK)
	begin
		if (RST || load_any)
			tog_cnt_r <= 6'd0;
		else if (mst && (sck_r != idle || m_tick) && m_tick)
			tog_cnt_r <= tog_cnt_r + 6'd1;
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	AST_READ_GIVES_BUF: assert property (rd_data |=> RDATA == $past(rdbuf_r))
		else $error("data read did not return read buffer");
	AST_WRITE_KEEPS_BUF: assert property (wr_data && !done_evt && !hold_rel |=> $stable(rdbuf_r))
		else $error("data write changed read buffer");
	AST_NO_LOAD_WHEN_FULL: assert property (done_evt && rbf_r && !rd_data |=> $stable(rdbuf_r) && state_r == ssp_pkg::SSP_HOLD)
		else $error("read buffer overwritten while unread");
	AST_BYTE_HIGH_KEPT: assert property (buf_load && !wide |=> rdbuf_r[15:8] == $past(rdbuf_r[15:8]))
		else $error("byte mode changed buffer high byte");
	AST_OVERRUN_SET: assert property (start_m && state_r == ssp_pkg::SSP_HOLD |=> ovr_r)
		else $error("overrun not flagged");
	AST_OVERRUN_STICKY: assert property (ovr_r && en && !wr_ctrl && !(wr_stat && WDATA[`SSP_ST_OVR]) |=> ovr_r)
		else $error("overrun cleared without a one written");
	AST_DISABLE_CLEARS: assert property (!en |=> !busy && !rbf_r && !ovr_r)
		else $error("disable left status set");
	AST_IRQ_FULL: assert property (rbf_r && read_full_irq_enable |=> IRQ)
		else $error("no interrupt on full buffer");
	AST_IRQ_IDLE: assert property (!busy && transfer_done_irq_enable |=> IRQ)
		else $error("no interrupt while idle");
	AST_IRQ_OVR: assert property (ovr_r && overrun_irq_enable_bit |=> IRQ)
		else $error("no interrupt on overrun");
	AST_PULSE_COUNT: assert property (m_done |-> tog_cnt_r == ({nbits, 1'b0} - 6'd1))
		else $error("master pulse count wrong");
	AST_IDLE_LEVEL: assert property (mst && !busy && $stable(idle) && !load_any && !wr_ctrl |=> SHIFT_CLOCK_PIN_O == idle)
		else $error("master clock not at idle level");
	AST_SLAVE_OFF: assert property (!mst && ss_n_q ##1 !wr_ctrl |-> !MASTER_IN_SLAVE_OUT_PIN_OE)
		else $error("slave drives output while deselected");
	AST_SLAVE_RESTART: assert property (s_restart |=> bitcnt_r == 5'd0)
		else $error("select release did not restart count");

	COV_MASTER_DONE: cover property (m_done && wide);
	COV_SLAVE_DONE: cover property (s_done && !wide);
	COV_OVERRUN: cover property (start_m && state_r == ssp_pkg::SSP_HOLD);
	COV_ECHO: cover property (out_evt && echo_act);

endmodule

`default_nettype wire

// ### tb/ssp_peer.sv
`timescale 1ns/10ps
`default_nettype none

// far-side serial slave, normal edges with the clock idle low
module ssp_peer (
	// shift clock and select from the master
	input  wire logic        sck,
	input  wire logic        sel_n,
	// serial data lines
	input  wire logic        mosi,
	output var  logic        miso,
	// word to send, its width, and what came in
	input  wire logic        wide,
	input  wire logic [15:0] tx,
	output var  logic [15:0] rx
);
	logic [15:0] sh_r; // outgoing word, shifted msb first

	initial
	begin
		miso = 1'b0;
		rx   = '0;
		sh_r = '0;
	end

	// selection loads the outgoing word and presents the top bit early
	always @(negedge sel_n)
	begin
		sh_r = tx;
		miso = wide ? tx[15] : tx[7];
	end

	// we only ever follow the master's clock, never make one
	always @(posedge sck)
	begin
		if (!sel_n)
			rx = {rx[14:0], mosi};
	end

	// next bit goes out on the falling edge
	always @(negedge sck)
	begin
		if (!sel_n)
		begin
			sh_r = sh_r << 1;
			miso = wide ? sh_r[15] : sh_r[7];
		end
	end

	// a released line must not keep showing the last bit
	always @(posedge sel_n)
		miso = ~miso;
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.svh"

module testbench;
	localparam logic [23:0] a_dat = `SSP_OFS_DATA; // data register
	localparam logic [23:0] a_ctl = `SSP_OFS_CTRL; // control register
	localparam logic [23:0] a_st  = `SSP_OFS_STAT; // status register

	logic        CLK, RST, WR, RD, IRQ;      // clock, reset, strobes, interrupt
	logic [23:0] ADDR;                       // register address
	logic [15:0] WDATA, RDATA;               // register data
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        tb_sck, tb_mosi, sel_n;     // our master-side drive
	logic        peer_miso, peer_wide;       // partner lines
	logic [15:0] peer_tx, peer_rx;           // partner words
	logic        sck_w, mosi_w, miso_w;      // resolved wires
	int          fails, n_checks, cycles, pulses, period;
	real         t_last;                     // time of last rising shift clock

	// each wire follows whoever enables onto it
	assign sck_w  = sck_oe ? sck_o : tb_sck;
	assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
	assign miso_w = miso_oe ? miso_o : peer_miso;

	ssp_top ssp_top_i (
		.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.SHIFT_CLOCK_PIN_I(sck_w), .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE(sck_oe),
		.MASTER_OUT_SLAVE_IN_PIN_I(mosi_w), .MASTER_OUT_SLAVE_IN_PIN_O(mosi_o),
		.MASTER_OUT_SLAVE_IN_PIN_OE(mosi_oe), .MASTER_IN_SLAVE_OUT_PIN_I(miso_w),
		.MASTER_IN_SLAVE_OUT_PIN_O(miso_o), .MASTER_IN_SLAVE_OUT_PIN_OE(miso_oe),
		.SLAVE_SELECT_N(sel_n), .IRQ(IRQ));

	ssp_peer ssp_peer_i (.sck(sck_w), .sel_n(sel_n), .mosi(mosi_w), .miso(peer_miso),
		.wide(peer_wide), .tx(peer_tx), .rx(peer_rx));

	// 200 MHz system clock
	always #2.5 CLK = ~CLK;

	// count shift clock pulses and the spacing of the last two
	always @(posedge sck_w)
	begin
		pulses++;
		period = int'(($realtime - t_last) / 5.0);
		t_last = $realtime;
	end

	// a hang is cut short well beyond the expected few hundred cycles
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end

	task results();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask

	// control word in field order: divider, idle, edges, irq enables, echo, width, role, on
	function automatic logic [15:0] cfg(input logic m, input logic w, input logic idl,
		input logic [2:0] irq, input logic [6:0] dv);
		cfg = {dv, idl, 1'b0, irq, 1'b0, w, m, 1'b1};
	endfunction

	task wr(input logic [23:0] a, input logic [15:0] d);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		@(posedge CLK);
	endtask

	// read data stand only in the cycle after the strobe
	task rc(input logic [23:0] a, input logic [15:0] e, input logic [15:0] msk);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(RDATA & msk, e);
		@(posedge CLK);
	endtask

	// one master transfer against the partner, judged at the wires
	task mxfer(input logic [15:0] d, input logic [15:0] p, input logic w, input int dv);
		logic [15:0] msk;
		msk       = w ? 16'hffff : 16'h00ff;
		peer_tx   = p;
		peer_wide = w;
		sel_n <= 1'b0;
		@(posedge CLK);
		pulses = 0;
		wr(a_dat, d);
		repeat ((w ? 32 : 16) * (dv + 1) + 6) @(posedge CLK);
		sel_n <= 1'b1;
		@(posedge CLK);
		chk(16'(pulses), w ? 16'h0010 : 16'h0008);
		chk(16'(period), 16'(2 * (dv + 1)));
		chk(peer_rx & msk, d & msk);
	endtask

	task t_reset();
		rc(a_ctl, 16'h0000, 16'hffff);
		rc(a_st, 16'h0000, 16'hffff);
		rc(24'hfffe66, 16'h0000, 16'hffff);
		chk({14'h0, sck_oe, miso_oe}, 16'h0000);
	endtask

	task t_master();
		wr(a_ctl, cfg(1, 1, 0, 3'b010, 1));
		rc(a_ctl, cfg(1, 1, 0, 3'b010, 1), 16'hffff);
		mxfer(16'h1234, 16'hbeef, 1, 1);
		rc(a_st, 16'h0002, 16'hffff);
		chk({15'h0, IRQ}, 16'h0001);
		rc(a_dat, 16'hbeef, 16'hffff);
		rc(a_st, 16'h0000, 16'hffff);
		chk({15'h0, IRQ}, 16'h0000);
	endtask

	// byte mode must leave the buffer's high byte alone
	task t_byte();
		wr(a_ctl, cfg(1, 0, 0, 3'b000, 2));
		mxfer(16'h77a5, 16'h0055, 0, 2);
		rc(a_dat, 16'hbe55, 16'hffff);
	endtask

	task t_overrun();
		wr(a_ctl, cfg(1, 0, 0, 3'b001, 1));
		mxfer(16'h0011, 16'h0022, 0, 1);
		mxfer(16'h0033, 16'h0044, 0, 1);
		rc(a_st, 16'h0003, 16'hffff);
		mxfer(16'h0055, 16'h0066, 0, 1);
		rc(a_st, 16'h0004, 16'h0004);
		chk({15'h0, IRQ}, 16'h0001);
		wr(a_st, 16'h0000);
		rc(a_st, 16'h0004, 16'h0004);
		rc(a_dat, 16'hbe22, 16'hffff);
		wr(a_st, 16'h0004);
		rc(a_st, 16'h0000, 16'h0004);
	endtask

	task t_disable();
		wr(a_ctl, 16'h0000);
		rc(a_st, 16'h0000, 16'hffff);
		wr(a_ctl, cfg(1, 0, 0, 3'b100, 1));
		@(posedge CLK);
		chk({15'h0, IRQ}, 16'h0001);
		wr(a_ctl, cfg(1, 0, 1, 3'b000, 1));
		// the clock flop takes the new idle level on the edge that ends the write
		@(posedge CLK);
		chk({15'h0, sck_o}, 16'h0001);
	endtask

	// we play master: the block must answer on our clock
	task t_slave();
		logic [7:0] got;
		wr(a_ctl, cfg(0, 0, 0, 3'b000, 0));
		wr(a_dat, 16'h00c3);
		chk({15'h0, miso_oe}, 16'h0000);
		sel_n <= 1'b0;
		repeat (6) @(posedge CLK);
		chk({14'h0, miso_oe, miso_o}, 16'h0003);
		for (int i = 0; i < 8; i++)
		begin
			tb_mosi <= 1'(8'h96 >> (7 - i));
			repeat (4) @(posedge CLK);
			got = {got[6:0], miso_w};
			tb_sck <= 1'b1;
			repeat (4) @(posedge CLK);
			tb_sck <= 1'b0;
		end
		repeat (6) @(posedge CLK);
		chk({8'h0, got}, 16'h00c3);
		sel_n <= 1'b1;
		repeat (6) @(posedge CLK);
		chk({15'h0, miso_oe}, 16'h0000);
		rc(a_dat, 16'h0096, 16'h00ff);
	endtask

	// echo on, no fresh data: each bit comes back one clock later
	task t_echo();
		logic [7:0] got;
		wr(a_ctl, cfg(0, 0, 0, 3'b000, 0) | 16'h0008);
		sel_n <= 1'b0;
		repeat (6) @(posedge CLK);
		for (int i = 0; i < 8; i++)
		begin
			tb_mosi <= 1'(8'h96 >> (7 - i));
			repeat (4) @(posedge CLK);
			got = {got[6:0], miso_w};
			tb_sck <= 1'b1;
			repeat (4) @(posedge CLK);
			tb_sck <= 1'b0;
		end
		repeat (6) @(posedge CLK);
		chk({8'h0, got}, 16'h004b);
		sel_n <= 1'b1;
		repeat (6) @(posedge CLK);
		rc(a_dat, 16'h0096, 16'h00ff);
	endtask

	initial
	begin
		CLK = 1'b0;
		RST = 1'b1;
		{WR, RD, tb_sck, tb_mosi, peer_wide} = '0;
		sel_n = 1'b1;
		ADDR = '0;
		WDATA = '0;
		peer_tx = '0;
		t_last = 0.0;
		{fails, n_checks, cycles, pulses, period} = '0;
		repeat (10) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		t_reset();
		t_master();
		t_byte();
		t_overrun();
		t_disable();
		t_slave();
		t_echo();
		results();
	end
endmodule
`default_nettype wire
